// ### design/pin_mode_cfg.svh
// constants for the direct-control pin mode logic
`ifndef PIN_MODE_CFG_SVH
`define PIN_MODE_CFG_SVH
`define CHANNELS 8
`define MAP_A_RESET 8'h04
`define MAP_B_RESET 8'h08
`define CTRL_RESET 8'h00
`define SYNC_STAGES 2
`endif

// ### design/pin_mode_pkg.sv
// types shared by the pin mode logic
package pin_mode_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FAILSAFE,
    MODE_SLEEP
  } op_mode_e;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] map_a;
    logic [7:0] map_b;
  } soft_regs_s;
endpackage

// ### design/pin_sync.sv
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // pins
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// ### design/control_pin_mode_logic.sv
// direct-control pin mode logic: input mapping, monitor and mode select
`timescale 1ns/10ps
`include "pin_mode_cfg.svh"

module control_pin_mode_logic #(
  parameter int CHANNELS = `CHANNELS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // control pins
  input wire logic i_direct_input_a,
  input wire logic i_direct_input_b,
  input wire logic i_idle_n,
  // serial side
  input wire logic i_chip_select_n,
  input wire logic i_so_data,
  input wire logic i_so_oe,
  // software register writes
  input wire logic i_ctrl_we,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic i_map_a_we,
  input wire logic [7:0] i_map_a_wdata,
  input wire logic i_map_b_we,
  input wire logic [7:0] i_map_b_wdata,
  // status and control outputs
  output logic [7:0] o_channel_on,
  output logic [1:0] o_input_level_monitor,
  output logic [7:0] o_ctrl,
  output logic [7:0] o_map_a,
  output logic [7:0] o_map_b,
  output logic o_spi_enable,
  output logic o_so_data,
  output logic o_so_oe,
  output logic o_uv_detect_enable,
  output logic o_failsafe,
  output logic o_sleep
);
  // =========================================================
  // pin synchronisation
  logic [2:0] pins_sync;
  logic in_a;
  logic in_b;
  logic idle_n;

  // idle travels inverted: a cleared synchroniser reads as awake, so no false sleep after reset
  pin_sync #(
    .WIDTH(3)
  ) i_pin_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({~i_idle_n, i_direct_input_b, i_direct_input_a}),
    .o_sync(pins_sync)
  );

  assign in_a = pins_sync[0];
  assign in_b = pins_sync[1];
  assign idle_n = !pins_sync[2];

  initial begin
    if (CHANNELS != 8) $error("control_pin_mode_logic serves exactly 8 channels");
  end

  // =========================================================
  // mode selection
  pin_mode_pkg::op_mode_e nxt_mode;
  // mode kept as registered flags so every mode output leaves a flip-flop
  logic spi_en_ff;
  logic uv_en_ff;
  logic failsafe_ff;
  logic sleep_ff;
  logic nxt_awake;
  logic nxt_failsafe;

  always_comb begin
    if (idle_n) begin
      nxt_mode = pin_mode_pkg::MODE_NORMAL;
    end else if (in_a || in_b) begin
      nxt_mode = pin_mode_pkg::MODE_FAILSAFE;
    end else begin
      nxt_mode = pin_mode_pkg::MODE_SLEEP;
    end
    nxt_awake = (nxt_mode != pin_mode_pkg::MODE_SLEEP);
    nxt_failsafe = (nxt_mode == pin_mode_pkg::MODE_FAILSAFE);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      spi_en_ff <= 1'b1;
      uv_en_ff <= 1'b1;
      failsafe_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else begin
      spi_en_ff <= nxt_awake;
      uv_en_ff <= nxt_awake;
      failsafe_ff <= nxt_failsafe;
      sleep_ff <= !nxt_awake;
    end
  end

  // =========================================================
  // software registers
  // held at default whenever idle is low, so fail-safe cannot inherit stale maps
  pin_mode_pkg::soft_regs_s regs_ff;
  pin_mode_pkg::soft_regs_s nxt_regs;

  always_comb begin
    nxt_regs = regs_ff;
    if (!idle_n) begin
      nxt_regs.ctrl = `CTRL_RESET;
      nxt_regs.map_a = `MAP_A_RESET;
      nxt_regs.map_b = `MAP_B_RESET;
    end else begin
      if (i_ctrl_we) begin
        nxt_regs.ctrl = i_ctrl_wdata;
      end
      if (i_map_a_we) begin
        nxt_regs.map_a = i_map_a_wdata;
      end
      if (i_map_b_we) begin
        nxt_regs.map_b = i_map_b_wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      regs_ff.ctrl <= `CTRL_RESET;
      regs_ff.map_a <= `MAP_A_RESET;
      regs_ff.map_b <= `MAP_B_RESET;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // =========================================================
  // channel drive, monitor and serial gating
  logic [7:0] channel_ff;
  logic [7:0] nxt_channel;
  logic [1:0] monitor_ff;
  logic [1:0] nxt_monitor;
  logic so_data_ff;
  logic so_oe_ff;
  logic nxt_so_oe;

  always_comb begin
    nxt_monitor = {in_b, in_a};
    case (nxt_mode)
      pin_mode_pkg::MODE_NORMAL: begin
        nxt_channel = regs_ff.ctrl | ({8{in_a}} & regs_ff.map_a) |
          ({8{in_b}} & regs_ff.map_b);
      end
      pin_mode_pkg::MODE_FAILSAFE: begin
        nxt_channel = ({8{in_a}} & `MAP_A_RESET) | ({8{in_b}} & `MAP_B_RESET);
      end
      pin_mode_pkg::MODE_SLEEP: begin
        nxt_channel = 8'h00;
      end
      default: begin
        nxt_channel = 8'h00;
      end
    endcase
    // transfers ignored in sleep even if chip select is low
    nxt_so_oe = i_so_oe && !i_chip_select_n &&
      (nxt_mode != pin_mode_pkg::MODE_SLEEP);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      channel_ff <= 8'h00;
      monitor_ff <= 2'h0;
      so_data_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      channel_ff <= nxt_channel;
      monitor_ff <= nxt_monitor;
      so_data_ff <= i_so_data;
      so_oe_ff <= nxt_so_oe;
    end
  end

  assign o_channel_on = channel_ff;
  assign o_input_level_monitor = monitor_ff;
  assign o_ctrl = regs_ff.ctrl;
  assign o_map_a = regs_ff.map_a;
  assign o_map_b = regs_ff.map_b;
  assign o_so_data = so_data_ff;
  assign o_so_oe = so_oe_ff;
  assign o_spi_enable = spi_en_ff;
  assign o_uv_detect_enable = uv_en_ff;
  assign o_failsafe = failsafe_ff;
  assign o_sleep = sleep_ff;

  // =========================================================
  // checks
  sequence s_sleep_pins;
    !idle_n && !in_a && !in_b;
  endsequence

  property p_sleep_entry;
    @(posedge i_clock) disable iff (i_srst)
      s_sleep_pins |=> o_sleep && !o_uv_detect_enable && !o_spi_enable;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_uv_off;
    @(posedge i_clock) disable iff (i_srst)
      s_sleep_pins |=> !o_uv_detect_enable;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("uv detect on in sleep");

  property p_failsafe_drive;
    @(posedge i_clock) disable iff (i_srst)
      (!idle_n && in_a && !in_b) |=> o_failsafe && (o_channel_on == 8'h04);
  endproperty
  a_failsafe_drive: assert property (p_failsafe_drive) else $error("bad fail-safe drive");

  property p_regs_default;
    @(posedge i_clock) disable iff (i_srst)
      !idle_n |=> (o_ctrl == 8'h00) && (o_map_a == 8'h04) && (o_map_b == 8'h08);
  endproperty
  a_regs_default: assert property (p_regs_default) else $error("regs not default");

  property p_monitor;
    @(posedge i_clock) disable iff (i_srst)
      1'b1 |=> o_input_level_monitor == $past({in_b, in_a});
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor stale");

  property p_monitor_failsafe;
    @(posedge i_clock) disable iff (i_srst)
      (!idle_n && in_b) |=> o_failsafe && (o_input_level_monitor == $past({in_b, in_a}));
  endproperty
  a_monitor_failsafe: assert property (p_monitor_failsafe) else $error("monitor frozen");

  property p_or_drive;
    @(posedge i_clock) disable iff (i_srst)
      (idle_n && in_a) |=> ((o_channel_on & $past(o_map_a)) == $past(o_map_a));
  endproperty
  a_or_drive: assert property (p_or_drive) else $error("mapped channel off");

  property p_map_write;
    @(posedge i_clock) disable iff (i_srst)
      (idle_n && i_map_b_we) |=> o_map_b == $past(i_map_b_wdata);
  endproperty
  a_map_write: assert property (p_map_write) else $error("map write lost");

  property p_sleep_quiet;
    @(posedge i_clock) disable iff (i_srst)
      s_sleep_pins |=> !o_so_oe && (o_channel_on == 8'h00);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in sleep");

  property p_sleep_off;
    @(posedge i_clock) disable iff (i_srst)
      o_sleep |-> o_channel_on == 8'h00;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep");

  property p_reset_map;
    @(posedge i_clock) i_srst |=> (o_map_a == 8'h04) && (o_map_b == 8'h08);
  endproperty
  a_reset_map: assert property (p_reset_map) else $error("bad reset map");
endmodule

// ### verif/host_pin_model.sv
// host model driving the direct-control and idle pins
`timescale 1ns/10ps
module host_pin_model #(
  parameter int HOLD_CYCLES = 6
) (
  // clock
  input wire logic i_clock,
  // pins towards the device
  output logic o_direct_input_a,
  output logic o_direct_input_b,
  output logic o_idle_n
);
  initial begin
    o_direct_input_a = 1'b0;
    o_direct_input_b = 1'b0;
    o_idle_n = 1'b1;
  end

  // new levels are held long enough to cover the sync and mode latency
  task automatic set_pins(input logic a, input logic b, input logic idle_n);
    @(posedge i_clock);
    o_direct_input_a <= a;
    o_direct_input_b <= b;
    o_idle_n <= idle_n;
    repeat (HOLD_CYCLES) @(posedge i_clock);
  endtask
endmodule

// ### verif/control_pin_mode_logic_tb.sv
// self-checking bench for the direct-control pin mode logic
`timescale 1ns/10ps
`define CHK(got, exp) check(32'(got), 32'(exp))
module control_pin_mode_logic_tb;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic pin_a, pin_b, idle_n, so_d, so_oe, spi_en, uv_en, failsafe, sleep;
  logic cs_n = 1'b1, so_data = 1'b0, so_req = 1'b0;
  logic ctrl_we = 1'b0, map_a_we = 1'b0, map_b_we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] channel_on, ctrl, map_a, map_b;
  logic [1:0] monitor;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  always #50 i_clock = ~i_clock;

  host_pin_model i_host_pin_model (.i_clock(i_clock), .o_direct_input_a(pin_a),
    .o_direct_input_b(pin_b), .o_idle_n(idle_n));

  control_pin_mode_logic i_control_pin_mode_logic (.i_clock(i_clock), .i_srst(i_srst),
    .i_direct_input_a(pin_a), .i_direct_input_b(pin_b), .i_idle_n(idle_n),
    .i_chip_select_n(cs_n), .i_so_data(so_data), .i_so_oe(so_req),
    .i_ctrl_we(ctrl_we), .i_ctrl_wdata(wdata), .i_map_a_we(map_a_we),
    .i_map_a_wdata(wdata), .i_map_b_we(map_b_we), .i_map_b_wdata(wdata),
    .o_channel_on(channel_on), .o_input_level_monitor(monitor), .o_ctrl(ctrl),
    .o_map_a(map_a), .o_map_b(map_b), .o_spi_enable(spi_en), .o_so_data(so_d),
    .o_so_oe(so_oe), .o_uv_detect_enable(uv_en), .o_failsafe(failsafe), .o_sleep(sleep));

  // ==========================================
  // helpers
  // values are sampled at the call, before the edge's updates land; only the compare waits one time unit
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    #1;
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one shared data bus, so one register per call
  task automatic write_reg(input int sel, input logic [7:0] data);
    @(posedge i_clock);
    wdata <= data;
    ctrl_we <= (sel == 0);
    map_a_we <= (sel == 1);
    map_b_we <= (sel == 2);
    @(posedge i_clock);
    {ctrl_we, map_a_we, map_b_we} <= 3'b000;
    repeat (2) @(posedge i_clock);
  endtask

  task automatic report_and_stop();
    $display("counts: comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================
  // scenarios
  task automatic t_reset();
    `CHK(map_a, 8'h04);
    `CHK(map_b, 8'h08);
    `CHK(ctrl, 8'h00);
    `CHK(channel_on, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_default_map();
    i_host_pin_model.set_pins(1'b1, 1'b0, 1'b1);
    `CHK(channel_on, 8'h04);
    `CHK(monitor, 2'b01);
    i_host_pin_model.set_pins(1'b0, 1'b1, 1'b1);
    `CHK(channel_on, 8'h08);
    `CHK(monitor, 2'b10);
    i_host_pin_model.set_pins(1'b0, 1'b0, 1'b1);
    `CHK(channel_on, 8'h00);
    $display("test default_map done");
  endtask

  task automatic t_mapping();
    write_reg(0, 8'h81);
    write_reg(1, 8'h30);
    write_reg(2, 8'h60);
    `CHK(map_a, 8'h30);
    `CHK(map_b, 8'h60);
    `CHK(channel_on, 8'h81);
    i_host_pin_model.set_pins(1'b1, 1'b0, 1'b1);
    `CHK(channel_on, 8'hB1);
    i_host_pin_model.set_pins(1'b1, 1'b1, 1'b1);
    `CHK(channel_on, 8'hF1);
    $display("test mapping done");
  endtask

  task automatic t_failsafe();
    i_host_pin_model.set_pins(1'b1, 1'b0, 1'b0);
    `CHK(failsafe, 1'b1);
    `CHK(channel_on, 8'h04);
    `CHK({ctrl, map_a, map_b}, 24'h00_0408);
    write_reg(0, 8'hFF);
    `CHK(ctrl, 8'h00);
    i_host_pin_model.set_pins(1'b1, 1'b1, 1'b0);
    `CHK(monitor, 2'b11);
    `CHK(channel_on, 8'h0C);
    $display("test failsafe done");
  endtask

  task automatic t_sleep();
    i_host_pin_model.set_pins(1'b0, 1'b0, 1'b1);
    @(posedge i_clock);
    cs_n <= 1'b0;
    so_req <= 1'b1;
    so_data <= 1'b1;
    repeat (2) @(posedge i_clock);
    `CHK({so_oe, so_d}, 2'b11);
    i_host_pin_model.set_pins(1'b0, 1'b0, 1'b0);
    `CHK(sleep, 1'b1);
    `CHK(uv_en, 1'b0);
    `CHK({spi_en, so_oe}, 2'b00);
    `CHK(channel_on, 8'h00);
    i_host_pin_model.set_pins(1'b0, 1'b0, 1'b1);
    `CHK({sleep, uv_en}, 2'h1);
    `CHK({spi_en, so_oe}, 2'h3);
    $display("test sleep done");
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_clock);
    t_reset();
    t_default_map();
    t_mapping();
    t_failsafe();
    t_sleep();
    report_and_stop();
  end
endmodule
